// ### hw/asr_pkg.sv
/*
 * Shared constants of the averaging converter serial readout port:
 * word layout, pin indices, timing counts and reset values.
 * Assumes a single 20 MHz system clock on the device side.
 */
package asr_pkg;

    // Output word layout
    localparam int RES_W = 24;
    localparam int CNT_W = 16;
    localparam int WORD_W = 40;
    localparam int ACC_W = 48;
    localparam int NCNT_W = 17;
    localparam int SHIFT_W = 5;
    localparam int RISE_W = 5;

    // Field positions inside the word
    localparam int WORD_MSB = 39;
    localparam int RES_LSB = 16;

    // Reset and limit values
    localparam logic [WORD_W-1:0] WORD_RST = 40'h00_0000_0000;
    localparam logic [ACC_W-1:0] ACC_RST = 48'h0000_0000_0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [RES_W-1:0] RES_MAX = 24'hffffff;
    localparam logic [NCNT_W-1:0] N_SAT = 17'h10000;
    localparam logic [SHIFT_W-1:0] SHIFT_MAX = 5'h10;

    // A read ends when a conversion cycle sees none or more than this many edges
    localparam logic [RISE_W-1:0] READ_END_EDGES = 5'h13;
    localparam logic [RISE_W-1:0] RISE_SAT = 5'h14;

    // Pin synchroniser slots
    localparam int PIN_N = 4;
    localparam int PIN_SCK = 0;
    localparam int PIN_GATE = 1;
    localparam int PIN_CHAIN = 2;
    localparam int PIN_STROBE = 3;
    // Idle pin levels; the gate rests high so a reset never drives a shared line
    localparam logic [PIN_N-1:0] PIN_IDLE = 4'h2;

    // Timing
    localparam int T_CLK_NS = 50;
    localparam int T_CONV_NS = 500;
    localparam int CONV_CYC = (T_CONV_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);

    // Result buffer shape
    localparam int FIFO_DEPTH = 8;

endpackage

// ### hw/asr_fifo.sv
/*
 * Small synchronous FIFO carrying conversion results toward the
 * averaging accumulator. Depth must be a power of two.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/1ps

module asr_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    logic [AW:0] next_fill;
    logic push;
    logic pop;

    // Handshakes on both sides
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Fill level after this cycle
    always_comb begin
        next_fill = fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // Storage has no reset; only pointers, fill level and flags have one
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and registered flags, so ready and valid come from flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill <= next_fill;
            in_ready <= next_fill != (AW+1)'(DEPTH);
            out_valid <= next_fill != '0;
        end
    end

endmodule // asr_fifo

// ### hw/asr_readout.sv
/*
 * Serial readout port of an averaging 24-bit converter: conversion
 * timing strobe, averaging accumulator, 40-bit output word shifted out
 * on the shift clock, in normal (gated) or chain mode.
 * Assumes all pins are asynchronous to clk and much slower than it;
 * results arrive from the converter core on a valid/ready port.
 */

`timescale 1ns/1ps

module asr_readout (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial pins
    input wire logic sck_pin,
    input wire logic readout_gate_or_link_in,
    input wire logic link_select,
    input wire logic convert_strobe,
    output logic sdo_out,
    output logic sdo_oe_b,
    output logic busy,
    // Conversion results from the core
    input wire logic conv_valid,
    input wire logic [asr_pkg::RES_W-1:0] conv_data,
    output logic conv_ready
);
    typedef enum logic {
        ASR_IDLE = 1'b0,
        ASR_CONV = 1'b1
    } asr_conv_e;

    logic [asr_pkg::PIN_N-1:0] pin_raw;
    logic [asr_pkg::PIN_N-1:0] sync1;
    logic [asr_pkg::PIN_N-1:0] sync2;
    logic [asr_pkg::PIN_N-1:0] sync3;
    logic [asr_pkg::PIN_N-1:0] pin_q;
    logic sck_prev;
    logic strobe_prev;
    logic sck_rise;
    logic strobe_rise;
    logic chain_mode;
    logic gate_or_sdi;
    logic shift_allowed;
    logic shift_en;
    asr_conv_e conv_state;
    logic [7:0] conv_cnt;
    logic busy_fall;
    logic in_read;
    logic start_read;
    logic end_read;
    logic reload;
    logic [asr_pkg::RISE_W-1:0] rise_cnt;
    logic [asr_pkg::ACC_W-1:0] acc;
    logic [asr_pkg::NCNT_W-1:0] n_acc;
    logic [asr_pkg::WORD_W-1:0] shreg;
    logic [asr_pkg::WORD_W-1:0] avg_word;
    logic [asr_pkg::RES_W-1:0] avg;
    logic [asr_pkg::CNT_W-1:0] cnt_field;
    logic [asr_pkg::ACC_W-1:0] acc_shifted;
    logic fifo_valid;
    logic fifo_ready;
    logic [asr_pkg::RES_W-1:0] fifo_data;
    logic take;

    // Averaging divisor exponent: smallest power of two not below n
    function automatic logic [asr_pkg::SHIFT_W-1:0] avg_shift(input logic [asr_pkg::NCNT_W-1:0] n);
        logic [asr_pkg::SHIFT_W-1:0] k;
        k = '0;
        for (int i = 0; i < asr_pkg::NCNT_W - 1; i++) begin
            if (n > (asr_pkg::NCNT_W'(1) << i)) begin
                k = asr_pkg::SHIFT_W'(i + 1);
            end
        end
        return k;
    endfunction

    assign pin_raw[asr_pkg::PIN_SCK] = sck_pin;
    assign pin_raw[asr_pkg::PIN_GATE] = readout_gate_or_link_in;
    assign pin_raw[asr_pkg::PIN_CHAIN] = link_select;
    assign pin_raw[asr_pkg::PIN_STROBE] = convert_strobe;

    // Three-stage pin synchronisers; a level counts once stages two and three agree
    for (genvar i = 0; i < asr_pkg::PIN_N; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                sync1[i] <= asr_pkg::PIN_IDLE[i];
                sync2[i] <= asr_pkg::PIN_IDLE[i];
                sync3[i] <= asr_pkg::PIN_IDLE[i];
                pin_q[i] <= asr_pkg::PIN_IDLE[i];
            end else begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                if (sync2[i] == sync3[i]) begin
                    pin_q[i] <= sync3[i];
                end
            end
        end
    end

    // Edge detectors on the filtered pins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sck_prev <= 1'b0;
            strobe_prev <= 1'b0;
        end else begin
            sck_prev <= pin_q[asr_pkg::PIN_SCK];
            strobe_prev <= pin_q[asr_pkg::PIN_STROBE];
        end
    end

    assign sck_rise = pin_q[asr_pkg::PIN_SCK] && !sck_prev;
    assign strobe_rise = pin_q[asr_pkg::PIN_STROBE] && !strobe_prev;
    assign chain_mode = pin_q[asr_pkg::PIN_CHAIN];
    assign gate_or_sdi = pin_q[asr_pkg::PIN_GATE];

    // Shift clock counts only while driving; a gated device ignores it
    assign shift_allowed = chain_mode || !gate_or_sdi;
    assign shift_en = sck_rise && shift_allowed && !reload;

    // Conversion timing: strobe rise starts busy, fixed count ends it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            conv_state <= ASR_IDLE;
            conv_cnt <= '0;
            busy <= 1'b0;
            busy_fall <= 1'b0;
        end else begin
            busy_fall <= 1'b0;
            unique case (conv_state)
                ASR_IDLE: begin
                    if (strobe_rise) begin
                        conv_state <= ASR_CONV;
                        conv_cnt <= asr_pkg::CONV_LAST;
                        busy <= 1'b1;
                    end
                end
                ASR_CONV: begin
                    if (conv_cnt == '0) begin
                        conv_state <= ASR_IDLE;
                        busy <= 1'b0;
                        busy_fall <= 1'b1;
                    end else begin
                        conv_cnt <= conv_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    // Read boundaries; the same in both modes
    assign start_read = sck_rise && shift_allowed && !in_read;
    assign end_read = busy_fall && in_read && (rise_cnt == '0 || rise_cnt > asr_pkg::READ_END_EDGES);
    assign reload = busy_fall && (!in_read || end_read);

    // Rising edges seen in the current conversion cycle, saturating
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rise_cnt <= '0;
        end else if (busy_fall) begin
            rise_cnt <= '0;
        end else if (sck_rise && shift_allowed && rise_cnt != asr_pkg::RISE_SAT) begin
            rise_cnt <= rise_cnt + 1'b1;
        end
    end

    // Read in progress flag; an edge on the closing cycle does not open the next one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            in_read <= 1'b0;
        end else if (start_read) begin
            in_read <= 1'b1;
        end else if (end_read) begin
            in_read <= 1'b0;
        end
    end

    // Results wait here; drain stalls on the reload cycle so the word is coherent
    asr_fifo #(
        .WIDTH(asr_pkg::RES_W),
        .DEPTH(asr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(conv_valid),
        .in_data(conv_data),
        .in_ready(conv_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_ready)
    );

    assign fifo_ready = !busy_fall;
    assign take = fifo_valid && fifo_ready;

    // Accumulator restarts at a read start; wraps only after 2^24 samples
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acc <= asr_pkg::ACC_RST;
            n_acc <= '0;
        end else if (start_read) begin
            acc <= take ? {{(asr_pkg::ACC_W - asr_pkg::RES_W){1'b0}}, fifo_data} : asr_pkg::ACC_RST;
            n_acc <= take ? asr_pkg::NCNT_W'(1) : '0;
        end else if (take) begin
            acc <= acc + {{(asr_pkg::ACC_W - asr_pkg::RES_W){1'b0}}, fifo_data};
            if (n_acc != asr_pkg::N_SAT) begin
                n_acc <= n_acc + 1'b1;
            end
        end
    end

    // Average and count fields of the next word
    always_comb begin
        acc_shifted = acc >> avg_shift(n_acc);
        if (acc_shifted[asr_pkg::ACC_W-1:asr_pkg::RES_W] != '0) begin
            avg = asr_pkg::RES_MAX;
        end else begin
            avg = acc_shifted[asr_pkg::RES_W-1:0];
        end
        if (n_acc == '0) begin
            cnt_field = '0;
        end else if (n_acc[asr_pkg::NCNT_W-1]) begin
            cnt_field = asr_pkg::CNT_MAX;
        end else begin
            cnt_field = n_acc[asr_pkg::CNT_W-1:0] - 1'b1;
        end
        avg_word = {avg, cnt_field};
    end

    // Output word: reload at read end or at a busy fall outside a read, else shift per edge, link data in at LSB
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shreg <= asr_pkg::WORD_RST;
        end else if (reload) begin
            shreg <= avg_word;
        end else if (shift_en) begin
            shreg <= {shreg[asr_pkg::WORD_MSB-1:0], chain_mode && gate_or_sdi};
        end
    end

    // Pin drivers; MSB is always present, so a falling gate shows it at once
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sdo_out <= 1'b0;
            sdo_oe_b <= 1'b1;
        end else begin
            sdo_out <= shreg[asr_pkg::WORD_MSB];
            sdo_oe_b <= !(chain_mode || !gate_or_sdi);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_gate_hiz: assert property ((!chain_mode && gate_or_sdi) |=> sdo_oe_b)
        else $error("output driven while gated");
    a_gate_drive: assert property ((!chain_mode && !gate_or_sdi) |=> !sdo_oe_b)
        else $error("output not driven with gate low");
    a_chain_drive: assert property (chain_mode |=> !sdo_oe_b)
        else $error("chain mode output not driven");
    a_msb_after_fall: assert property (reload |=> ##1 (sdo_out == $past(avg_word[asr_pkg::WORD_MSB], 2)))
        else $error("result msb not shown after busy fall");
    a_gate_ignores: assert property ((!chain_mode && gate_or_sdi && sck_rise && !reload) |=> $stable(shreg))
        else $error("gated device shifted");
    a_chain_shift_in: assert property ((chain_mode && sck_rise && !reload)
        |=> shreg == {$past(shreg[asr_pkg::WORD_MSB-1:0]), $past(gate_or_sdi)})
        else $error("chain data not shifted in at lsb");
    a_read_clears_acc: assert property (start_read |=> n_acc <= asr_pkg::NCNT_W'(1))
        else $error("accumulator not cleared at read start");
    a_read_holds: assert property ((busy_fall && in_read && rise_cnt != '0
        && rise_cnt <= asr_pkg::READ_END_EDGES && !sck_rise) |=> $stable(shreg) && in_read)
        else $error("word reloaded during distributed read");
    a_read_ends: assert property ((busy_fall && in_read && rise_cnt == '0) |=> !in_read)
        else $error("idle cycle did not end read");

    c_read_start: cover property (start_read ##[1:200] end_read);
    c_chain_shift: cover property (chain_mode && shift_en);
    c_long_read: cover property (busy_fall && rise_cnt > asr_pkg::READ_END_EDGES);
    c_fifo_full: cover property (!conv_ready);

endmodule // asr_readout

// ### tb/asr_host_model.sv
/*
 * Host serial controller model: drives the shift clock, convert strobe,
 * gate or chain data and link select, and samples the data line.
 * Assumes the caller invokes its tasks just after a rising clk edge.
 */
`timescale 1ns/1ps

module asr_host_model (
    // Clock
    input wire logic clk,
    // Device outputs
    input wire logic sdo_out,
    input wire logic sdo_oe_b,
    input wire logic busy,
    // Host-driven pins
    output logic sck_pin,
    output logic gate_link,
    output logic link_select,
    output logic convert_strobe
);
    logic last_sdo = 1'b0;
    logic sdo_line;

    // Released line has no pull, so show the inverse of the last driven bit
    always @(posedge clk) begin
        if (!sdo_oe_b) last_sdo <= sdo_out;
    end
    assign sdo_line = sdo_oe_b ? ~last_sdo : sdo_out;

    // Gates idle high so no two devices ever share the line
    initial begin
        sck_pin = 1'b0;
        gate_link = 1'b1;
        link_select = 1'b0;
        convert_strobe = 1'b0;
    end

    task set_gate(input logic v);
        gate_link = v;
    endtask

    task set_chain(input logic v);
        link_select = v;
    endtask

    // Strobe held six clocks so the pin filter sees it; counts busy-high clocks
    task convert(output int hi);
        int i;
        @(posedge clk);
        #1;
        convert_strobe = 1'b1;
        hi = 0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (i == 5) convert_strobe = 1'b0;
            if (busy === 1'b1) hi++;
            else if (hi > 0) break;
        end
    endtask

    // Sample each bit before its rising edge; half period 200 ns
    task shift(input int n, input logic [79:0] din, output logic [79:0] q);
        q = '0;
        for (int i = 0; i < n; i++) begin
            if (link_select) gate_link = din[79-i];
            repeat (4) @(posedge clk);
            #1;
            q = {q[78:0], sdo_line};
            sck_pin = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            sck_pin = 1'b0;
        end
    endtask
endmodule // asr_host_model

// ### tb/tb_adc_serial_readout_chain.sv
/*
 * Self-checking bench for the serial readout port: normal mode gating,
 * word layout, distributed read and reload, chain mode pass-through.
 * Assumes the host model in asr_host_model.sv and a 50 ns clock.
 */
`timescale 1ns/1ps

module tb_adc_serial_readout_chain;
    // Clock, reset, core side
    logic clk;
    logic rst_b;
    logic conv_valid;
    logic [asr_pkg::RES_W-1:0] conv_data;
    logic conv_ready;
    // Pins
    logic sck_pin, gate_link, link_select, convert_strobe;
    logic sdo_out, sdo_oe_b, busy;
    int bad_count;
    int cmp_count;
    int hi;
    logic [79:0] q;
    logic [79:0] q2;

    asr_readout uut (.clk(clk), .rst_b(rst_b), .sck_pin(sck_pin), .readout_gate_or_link_in(gate_link),
        .link_select(link_select), .convert_strobe(convert_strobe), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b),
        .busy(busy), .conv_valid(conv_valid), .conv_data(conv_data), .conv_ready(conv_ready));

    asr_host_model host (.clk(clk), .sdo_out(sdo_out), .sdo_oe_b(sdo_oe_b), .busy(busy), .sck_pin(sck_pin),
        .gate_link(gate_link), .link_select(link_select), .convert_strobe(convert_strobe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task stop_test;
        $display("counts: %0d compared, %0d mismatched", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Bounded wait for the enable (oe=1) or the data line to reach v
    task wait_pin(input logic v, input bit oe, input int n);
        int i;
        cmp_count++;
        for (i = 0; i < n; i++) begin
            if ((oe ? sdo_oe_b : host.sdo_line) === v) break;
            @(posedge clk);
            #1;
        end
        if (i == n) begin
            bad_count++;
            $display("mismatch at %0t: pin never reached %b", $time, v);
            stop_test();
        end
    endtask

    task push(input logic [23:0] d);
        int i;
        @(posedge clk);
        #1;
        conv_valid = 1'b1;
        conv_data = d;
        for (i = 0; i < 20 && conv_ready !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 20) begin
            bad_count++;
            $display("mismatch at %0t: result port never ready", $time);
            stop_test();
        end
        @(posedge clk);
        #1;
        conv_valid = 1'b0;
    endtask

    // A busy pulse of the wrong length or none at all ends the run
    task do_convert;
        host.convert(hi);
        chk(40'(hi), 40'(asr_pkg::CONV_CYC), "busy length");
        if (hi != asr_pkg::CONV_CYC) stop_test();
    endtask

    // Gate high ignores clocks; gate low drives MSB at once; full word layout
    task test_normal;
        push(24'hf00000);
        push(24'he00000);
        do_convert();
        host.shift(5, '0, q);
        chk(40'(sdo_oe_b), 40'h1, "released while gate high");
        host.set_gate(1'b0);
        wait_pin(1'b0, 1'b1, 20);
        wait_pin(1'b1, 1'b0, 4);
        host.shift(40, '0, q);
        chk(q[39:0], 40'he80000_0001, "word after ignored clocks");
        $display("test normal done");
    endtask

    // MSB after busy falls without clocks; distributed read keeps the word
    task test_reload;
        push(24'h923456);
        do_convert();
        chk(40'(host.sdo_line), 40'h0, "old word before reload");
        wait_pin(1'b1, 1'b0, 4);
        host.shift(8, '0, q);
        push(24'h000010);
        do_convert();
        host.shift(32, '0, q2);
        chk({q[7:0], q2[31:0]}, 40'h923456_0000, "distributed read");
        do_convert();
        // Short read, one held cycle, then an edgeless cycle ends it
        host.shift(2, '0, q);
        push(24'h000300);
        do_convert();
        push(24'h000500);
        do_convert();
        host.shift(40, '0, q);
        chk(q[39:0], 40'h000400_0001, "word after edgeless cycle");
        push(24'h000010);
        $display("test reload done");
    endtask

    // Chain mode: always driven, upstream word follows after 40 clocks
    task test_chain;
        host.set_gate(1'b1);
        wait_pin(1'b1, 1'b1, 20);
        host.set_chain(1'b1);
        wait_pin(1'b0, 1'b1, 20);
        do_convert();
        host.shift(80, {40'ha5c30f965a, 40'h0}, q);
        chk(q[79:40], 40'h000010_0000, "own word in chain");
        chk(q[39:0], 40'ha5c30f965a, "upstream word");
        $display("test chain done");
    endtask

    initial begin
        rst_b = 1'b0;
        conv_valid = 1'b0;
        conv_data = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk({36'h0, busy, sdo_oe_b, sdo_out, conv_ready}, 40'h5, "reset levels");
        $display("test reset done");
        test_normal();
        test_reload();
        test_chain();
        stop_test();
    end
endmodule // tb_adc_serial_readout_chain
